// ==== src/piom_top.sv ====
// Three general-purpose ports with latches, pin reads, pull-up control and carrier modulation
// Overview of operation
// - Latches at 0x80/0x90/0xA0 take byte and bit writes; other registers byte only.
// - An enabled peripheral owns its pin's driven level instead of the latch.
// - Each pin has its own weak pull-up, all enabled after reset.
// - Pull-up disabled means open drain: low for zero, released for one.
// - A port write strobe loads the data bus into that port's latch.
// - A latch read returns the stored latch contents.
// - A pin read returns the synchronised external pin levels.
// - Pulled-up pin is driven low for zero, left to the pull-up for one.
// - Open-drain output drives low for zero; external resistor makes high.
// - A modulated pin outputs its level XOR the 38 kHz carrier.
// - The global carrier enable input gates all modulation.
// - Modulation select register, reset zero, maps eight bits to eight pins.
// - First pull-up register bit n disables port 0 pin n pull-up.
// - Second pull-up register bit n disables port 1 pin n pull-up.
// - Third register bits 0-2 pins, bit 4 access pin, bit 5 reset pin.
// - Port latch bits reset to one and are readable and writable.
`timescale 1ns/1ps
module piom_top #(
	parameter int CLK_HZ     = piom_pkg::CLK_HZ,
	parameter int CARRIER_HZ = piom_pkg::CARRIER_HZ
) (
	// Clock and reset
	input  wire logic                           I_CORE_CLK,
	input  wire logic                           I_RST,
	// Special-function register bus, byte access
	input  wire logic [7:0]                     I_SFR_ADDR,
	input  wire logic [7:0]                     I_SFR_WDATA,
	input  wire logic                           I_SFR_WR,
	input  wire logic                           I_SFR_RD,
	input  wire logic                           I_SFR_RD_PIN,
	// Special-function register bus, bit access
	input  wire logic [7:0]                     I_SFR_BIT_ADDR,
	input  wire logic                           I_SFR_BIT_WDATA,
	input  wire logic                           I_SFR_BIT_WR,
	input  wire logic                           I_SFR_BIT_RD,
	// Read answer
	output logic      [7:0]                     O_SFR_RDATA,
	output logic                                O_SFR_RVALID,
	// Configuration and peripheral hand-off
	input  wire logic                           I_CARRIER_GLOBAL_ENABLE,
	input  wire logic [piom_pkg::NUM_PINS-1:0]  I_ALT_EN,
	input  wire logic [piom_pkg::NUM_PINS-1:0]  I_ALT_OUT,
	// Pins
	input  wire logic [piom_pkg::NUM_PINS-1:0]  I_PIN_IN,
	output logic      [piom_pkg::NUM_PINS-1:0]  O_PIN_OUT,
	output logic      [piom_pkg::NUM_PINS-1:0]  O_PIN_OE,
	output logic      [piom_pkg::NUM_PINS-1:0]  O_PULLUP_EN,
	output logic                                O_EA_PULLUP_EN,
	output logic                                O_RESET_PULLUP_EN
);

	localparam int NP = piom_pkg::NUM_PORTS;
	localparam int PW = piom_pkg::PORT_W;
	localparam int NPIN = piom_pkg::NUM_PINS;

	// True when a bit address falls in the given port's latch
	function automatic logic bit_hit(input logic [7:0] addr, input logic [7:0] base);
		bit_hit = (addr[7:piom_pkg::BIT_IDX_W] == base[7:piom_pkg::BIT_IDX_W]);
	endfunction

	// Expands the modulation select bits into a per-pin mask
	function automatic logic [NPIN-1:0] mod_mask(input logic [piom_pkg::MOD_SEL_W-1:0] sel);
		logic [NPIN-1:0] m;
		m = '0;
		for (int k = 0; k < piom_pkg::MOD_SEL_W; k++)
			m[piom_pkg::MOD_PIN[k]] = sel[k];
		return m;
	endfunction

	logic [PW-1:0]                      latch_q [NP];
	logic [NPIN-1:0]                    latch_flat;
	logic [piom_pkg::MOD_SEL_W-1:0]     mod_sel_q;
	logic [PW-1:0]                      pud0_q;
	logic [PW-1:0]                      pud1_q;
	logic [PW-1:0]                      pud2_q;
	logic [NPIN-1:0]                    pud_pins;
	logic [NPIN-1:0]                    pin_level;
	logic [NPIN-1:0]                    pin_mask;
	logic [NPIN-1:0]                    drive_d;
	logic                               carrier;
	logic [7:0]                         rdata_d;
	logic [piom_pkg::BIT_IDX_W-1:0]     bit_idx;

	assign bit_idx = I_SFR_BIT_ADDR[piom_pkg::BIT_IDX_W-1:0];

	// Pin inputs cross in from the outside world
	piom_sync #(
		.WIDTH (NPIN),
		.IDLE  (piom_pkg::PIN_IDLE)
	) u_sync (
		.i_clk   (I_CORE_CLK),
		.i_rst   (I_RST),
		.i_async (I_PIN_IN),
		.o_level (pin_level)
	);

	// Carrier for the modulated pins
	piom_carrier #(
		.CLK_HZ     (CLK_HZ),
		.CARRIER_HZ (CARRIER_HZ)
	) u_carrier (
		.i_clk     (I_CORE_CLK),
		.i_rst     (I_RST),
		.o_carrier (carrier)
	);

	// Port latches: byte write wins if a bit write hits the same port in one cycle
	for (genvar p = 0; p < NP; p++)
	begin : g_latch
		always_ff @(posedge I_CORE_CLK)
		begin
			if (I_RST)
				latch_q[p] <= piom_pkg::LATCH_RST;
			else if (I_SFR_WR && I_SFR_ADDR == piom_pkg::PORT_ADDR[p])
				latch_q[p] <= I_SFR_WDATA;
			else if (I_SFR_BIT_WR && bit_hit(I_SFR_BIT_ADDR, piom_pkg::PORT_ADDR[p]))
				latch_q[p][bit_idx] <= I_SFR_BIT_WDATA;
		end
		assign latch_flat[p*PW +: PW] = latch_q[p];
	end

	// Byte-only configuration registers
	always_ff @(posedge I_CORE_CLK)
	begin
		if (I_RST)
		begin
			mod_sel_q <= piom_pkg::MOD_SEL_RST;
			pud0_q    <= piom_pkg::PUD_RST;
			pud1_q    <= piom_pkg::PUD_RST;
			pud2_q    <= piom_pkg::PUD_RST;
		end
		else if (I_SFR_WR)
		begin
			case (I_SFR_ADDR)
				piom_pkg::MOD_SEL_ADDR: mod_sel_q <= I_SFR_WDATA;
				piom_pkg::PUD0_ADDR:    pud0_q    <= I_SFR_WDATA;
				piom_pkg::PUD1_ADDR:    pud1_q    <= I_SFR_WDATA;
				piom_pkg::PUD2_ADDR:    pud2_q    <= I_SFR_WDATA & piom_pkg::PUD2_MASK;
				default:                ;
			endcase
		end
	end

	// Read mux: latch or pin path chosen by the CPU per instruction kind
	always_comb
	begin
		rdata_d = '0;
		if (I_SFR_RD)
		begin
			for (int p = 0; p < NP; p++)
				if (I_SFR_ADDR == piom_pkg::PORT_ADDR[p])
					rdata_d = I_SFR_RD_PIN ? pin_level[p*PW +: PW] : latch_q[p];
			case (I_SFR_ADDR)
				piom_pkg::MOD_SEL_ADDR: rdata_d = mod_sel_q;
				piom_pkg::PUD0_ADDR:    rdata_d = pud0_q;
				piom_pkg::PUD1_ADDR:    rdata_d = pud1_q;
				piom_pkg::PUD2_ADDR:    rdata_d = pud2_q;
				default:                ;
			endcase
		end
		else if (I_SFR_BIT_RD)
		begin
			for (int p = 0; p < NP; p++)
				if (bit_hit(I_SFR_BIT_ADDR, piom_pkg::PORT_ADDR[p]))
					rdata_d[0] = I_SFR_RD_PIN ? pin_level[p*PW + int'(bit_idx)] : latch_q[p][bit_idx];
		end
	end

	// Read answer one cycle after the request; unmapped addresses read zero
	always_ff @(posedge I_CORE_CLK)
	begin
		if (I_RST)
		begin
			O_SFR_RDATA  <= '0;
			O_SFR_RVALID <= 1'b0;
		end
		else
		begin
			O_SFR_RDATA  <= rdata_d;
			O_SFR_RVALID <= I_SFR_RD | I_SFR_BIT_RD;
		end
	end

	// Per-pin pull-up disables; port 2 only has pins 0..2 in its register
	assign pud_pins = {pud2_q & piom_pkg::PUD2_PIN_MASK, pud1_q, pud0_q};
	assign pin_mask = mod_mask(mod_sel_q) & {NPIN{I_CARRIER_GLOBAL_ENABLE}};

	// Driven level per pin: peripheral or latch, then optional carrier XOR
	for (genvar i = 0; i < NPIN; i++)
	begin : g_pin
		always_comb
		begin
			drive_d[i] = I_ALT_EN[i] ? I_ALT_OUT[i] : latch_flat[i];
			drive_d[i] = drive_d[i] ^ (pin_mask[i] & carrier);
		end
	end

	// Pins only ever pull low; a one is left to the pull-up or outside resistor
	always_ff @(posedge I_CORE_CLK)
	begin
		if (I_RST)
		begin
			O_PIN_OUT <= piom_pkg::PIN_IDLE;
			O_PIN_OE  <= '0;
		end
		else
		begin
			O_PIN_OUT <= drive_d;
			O_PIN_OE  <= ~drive_d;
		end
	end

	// Pull-up enables, registered so glitches never reach the pads
	always_ff @(posedge I_CORE_CLK)
	begin
		if (I_RST)
		begin
			O_PULLUP_EN       <= '1;
			O_EA_PULLUP_EN    <= 1'b1;
			O_RESET_PULLUP_EN <= 1'b1;
		end
		else
		begin
			O_PULLUP_EN       <= ~pud_pins;
			O_EA_PULLUP_EN    <= ~pud2_q[piom_pkg::PUD2_EA_BIT];
			O_RESET_PULLUP_EN <= ~pud2_q[piom_pkg::PUD2_RST_BIT];
		end
	end

	// Checks
	property p_latch_reset;
		@(posedge I_CORE_CLK) I_RST |=> latch_q[0] == piom_pkg::LATCH_RST && latch_q[1] == piom_pkg::LATCH_RST;
	endproperty
	a_latch_reset: assert property (p_latch_reset) else $error("Latch not all ones after reset");

	property p_cfg_reset;
		@(posedge I_CORE_CLK) I_RST |=> mod_sel_q == '0 && pud0_q == '0 && pud1_q == '0 && pud2_q == '0;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) else $error("Config register not zero after reset");

	property p_byte_write;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		I_SFR_WR && I_SFR_ADDR == piom_pkg::PORT_ADDR[1] |=> latch_q[1] == $past(I_SFR_WDATA);
	endproperty
	a_byte_write: assert property (p_byte_write) else $error("Port latch missed byte write");

	property p_bit_write;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		I_SFR_BIT_WR && !I_SFR_WR && bit_hit(I_SFR_BIT_ADDR, piom_pkg::PORT_ADDR[0])
		|=> latch_q[0][$past(bit_idx)] == $past(I_SFR_BIT_WDATA)
			&& ((latch_q[0] ^ $past(latch_q[0])) & ~(8'h01 << $past(bit_idx))) == '0;
	endproperty
	a_bit_write: assert property (p_bit_write) else $error("Bit write wrong or disturbed neighbours");

	property p_latch_read;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		I_SFR_RD && !I_SFR_RD_PIN && I_SFR_ADDR == piom_pkg::PORT_ADDR[0]
		|=> O_SFR_RVALID && O_SFR_RDATA == $past(latch_q[0]);
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("Latch read returned wrong data");

	property p_bit_read;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		I_SFR_BIT_RD && !I_SFR_RD && !I_SFR_RD_PIN && bit_hit(I_SFR_BIT_ADDR, piom_pkg::PORT_ADDR[1])
		|=> O_SFR_RVALID && O_SFR_RDATA == {7'h00, $past(latch_q[1][bit_idx])};
	endproperty
	a_bit_read: assert property (p_bit_read) else $error("Bit read returned wrong latch bit");

	property p_pin_read;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		I_SFR_RD && I_SFR_RD_PIN && I_SFR_ADDR == piom_pkg::PORT_ADDR[2]
		|=> O_SFR_RVALID && O_SFR_RDATA == $past(pin_level[2*PW +: PW]);
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("Pin read returned wrong data");

	property p_drive_plain;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		!I_CARRIER_GLOBAL_ENABLE && I_ALT_EN == '0 |=> O_PIN_OE == ~$past(latch_flat);
	endproperty
	a_drive_plain: assert property (p_drive_plain) else $error("Pin drive does not follow latch");

	property p_alt_drive;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		I_ALT_EN[0] |=> O_PIN_OE[0] == !$past(I_ALT_OUT[0]);
	endproperty
	a_alt_drive: assert property (p_alt_drive) else $error("Peripheral did not own its pin");

	property p_modulate;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		I_CARRIER_GLOBAL_ENABLE && mod_sel_q[0] && !I_ALT_EN[3]
		|=> O_PIN_OUT[3] == ($past(latch_flat[3]) ^ $past(carrier)) && O_PIN_OE[3] == !O_PIN_OUT[3];
	endproperty
	a_modulate: assert property (p_modulate) else $error("Modulated pin is not level XOR carrier");

	property p_pullup;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		1'b1 |=> O_PULLUP_EN == ~$past(pud_pins) && O_RESET_PULLUP_EN == !$past(pud2_q[piom_pkg::PUD2_RST_BIT]);
	endproperty
	a_pullup: assert property (p_pullup) else $error("Pull-up enable does not follow register");

	c_pin_read: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) I_SFR_RD && I_SFR_RD_PIN ##1 O_SFR_RVALID);
	c_bit_write: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) I_SFR_BIT_WR ##1 $changed(latch_flat));
	c_modulated: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) pin_mask != '0 ##1 $changed(O_PIN_OUT));
	c_open_drain: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) O_PULLUP_EN != '1 && O_PIN_OE != '0);

endmodule

// ==== src/piom_pkg.sv ====
// Package with addresses, reset values and timing for the parallel port block
package piom_pkg;

	// Port geometry
	localparam int NUM_PORTS  = 3;
	localparam int PORT_W     = 8;
	localparam int NUM_PINS   = NUM_PORTS * PORT_W;
	localparam int BIT_IDX_W  = 3;
	localparam int MOD_SEL_W  = 8;
	localparam int PIN_IDX_W  = 5;

	// Byte addresses; latch bit addresses are base plus bit index
	localparam logic [NUM_PORTS-1:0][7:0] PORT_ADDR = {8'hA0, 8'h90, 8'h80};
	localparam logic [7:0] MOD_SEL_ADDR = 8'h9F;
	localparam logic [7:0] PUD0_ADDR    = 8'hB2;
	localparam logic [7:0] PUD1_ADDR    = 8'hB3;
	localparam logic [7:0] PUD2_ADDR    = 8'hB4;

	// Reset values
	localparam logic [PORT_W-1:0]    LATCH_RST   = 8'hFF;
	localparam logic [PORT_W-1:0]    PUD_RST     = 8'h00;
	localparam logic [MOD_SEL_W-1:0] MOD_SEL_RST = 8'h00;
	localparam logic [NUM_PINS-1:0]  PIN_IDLE    = 24'hFF_FFFF;

	// Third pull-up register: pins 0..2, bit 4 access-select pin, bit 5 reset pin
	localparam logic [PORT_W-1:0] PUD2_MASK     = 8'h37;
	localparam logic [PORT_W-1:0] PUD2_PIN_MASK = 8'h07;
	localparam int PUD2_EA_BIT  = 4;
	localparam int PUD2_RST_BIT = 5;

	// Pin index (port * 8 + bit) steered by each modulation select bit
	localparam logic [MOD_SEL_W-1:0][PIN_IDX_W-1:0] MOD_PIN =
		{5'h0E, 5'h0D, 5'h0C, 5'h09, 5'h02, 5'h07, 5'h05, 5'h03};

	// Carrier timing
	localparam int CLK_HZ     = 250_000_000;
	localparam int CARRIER_HZ = 38_000;

endpackage

// ==== src/piom_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module piom_sync #(
	parameter int                WIDTH = 24,
	parameter logic [WIDTH-1:0]  IDLE  = '1
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// Raw pins and filtered level
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_level
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// Stage one is read only by stage two, to keep metastability contained
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s1_q <= IDLE;
			s2_q <= IDLE;
			s3_q <= IDLE;
		end
		else
		begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit changes only once stages two and three agree
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_level <= IDLE;
		else
			o_level <= (s2_q & s3_q) | (o_level & (s2_q ^ s3_q));
	end

endmodule

// ==== src/piom_carrier.sv ====
// Square-wave carrier divided down from the core clock
`timescale 1ns/1ps
module piom_carrier #(
	parameter int CLK_HZ     = piom_pkg::CLK_HZ,
	parameter int CARRIER_HZ = piom_pkg::CARRIER_HZ
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Carrier out
	output logic      o_carrier
);

	// Half period rounded to nearest, so the rate is as close as the divider allows
	localparam int HALF   = (CLK_HZ + CARRIER_HZ) / (2 * CARRIER_HZ);
	localparam int CNT_W  = $clog2(HALF);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF - 1);

	logic [CNT_W-1:0] cnt_q;

	// Half-period counter and toggle
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			cnt_q     <= '0;
			o_carrier <= 1'b0;
		end
		else if (cnt_q == LAST)
		begin
			cnt_q     <= '0;
			o_carrier <= ~o_carrier;
		end
		else
			cnt_q <= cnt_q + 1'b1;
	end

	// The carrier may only flip when the counter has just reached its last value
	property p_half_period;
		@(posedge i_clk) disable iff (i_rst)
		$changed(o_carrier) && !$past(i_rst) |-> $past(cnt_q) == LAST;
	endproperty
	a_half_period: assert property (p_half_period) else $error("Carrier toggled off its half period");

endmodule

// ==== testbench/piom_pins_model.sv ====
// Board model around the pins: external drivers, pull-up resistors and floating lines
`timescale 1ns/1ps
module piom_pins_model (
	// Clock for the floating-line pattern
	input  wire logic        i_clk,
	// Device pin controls
	input  wire logic [23:0] i_oe,
	input  wire logic [23:0] i_pu,
	// Board drivers and resistors
	input  wire logic [23:0] i_ext_en,
	input  wire logic [23:0] i_ext_val,
	input  wire logic [23:0] i_ext_res,
	// Resolved wire level
	output logic      [23:0] o_level
);
	logic [23:0] flt_q = 24'h00_0000;

	// An undriven line wanders every cycle, so nobody can rely on its last level
	always @(posedge i_clk)
		flt_q <= ~flt_q;

	// Device low wins; otherwise a board driver, then a weak or board pull-up
	always_comb
		for (int i = 0; i < 24; i++)
			o_level[i] = i_oe[i] ? 1'b0 : i_ext_en[i] ? i_ext_val[i] : (i_pu[i] | i_ext_res[i]) ? 1'b1 : flt_q[i];
endmodule

// ==== testbench/piom_bench.sv ====
// Self-checking bench: register, pin and carrier checks against a reference model
`timescale 1ns/1ps
module piom_bench;
	// Short carrier period keeps the run brief
	localparam int CLK  = 1000;
	localparam int CAR  = 100;
	localparam int HALF = CLK / (2 * CAR);
	localparam logic [7:0] ADR [8] = '{8'h80, 8'h90, 8'hA0, 8'h9F, 8'hB2, 8'hB3, 8'hB4, 8'hB5};

	// Bench signals and model state
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        wr = 1'b0, rd = 1'b0, rdp = 1'b0, bwd = 1'b0, bwr = 1'b0, brd = 1'b0, gen = 1'b0;
	logic [7:0]  addr = 8'h00, wdat = 8'h00, baddr = 8'h00, rdat, g;
	logic        rvld, ea_pu, rs_pu;
	logic [23:0] alt_en = 24'h00_0000, alt_out = 24'h00_0000, xen = 24'h00_0000, xval = 24'h00_0000;
	logic [23:0] pin, pout, oe, pu, ch, e;
	int          failures = 0, num_checks = 0, cyc = 0, iv, a;
	int          mdl [int];

	// Device under test
	piom_top #(.CLK_HZ(CLK), .CARRIER_HZ(CAR)) i_dut (
		.I_CORE_CLK              (clk),
		.I_RST                   (rst),
		.I_SFR_ADDR              (addr),
		.I_SFR_WDATA             (wdat),
		.I_SFR_WR                (wr),
		.I_SFR_RD                (rd),
		.I_SFR_RD_PIN            (rdp),
		.I_SFR_BIT_ADDR          (baddr),
		.I_SFR_BIT_WDATA         (bwd),
		.I_SFR_BIT_WR            (bwr),
		.I_SFR_BIT_RD            (brd),
		.O_SFR_RDATA             (rdat),
		.O_SFR_RVALID            (rvld),
		.I_CARRIER_GLOBAL_ENABLE (gen),
		.I_ALT_EN                (alt_en),
		.I_ALT_OUT               (alt_out),
		.I_PIN_IN                (pin),
		.O_PIN_OUT               (pout),
		.O_PIN_OE                (oe),
		.O_PULLUP_EN             (pu),
		.O_EA_PULLUP_EN          (ea_pu),
		.O_RESET_PULLUP_EN       (rs_pu)
	);

	// Board around the pins; every line has a board pull-up
	piom_pins_model i_pins (
		.i_clk     (clk),
		.i_oe      (oe),
		.i_pu      (pu),
		.i_ext_en  (xen),
		.i_ext_val (xval),
		.i_ext_res (24'hFF_FFFF),
		.o_level   (pin)
	);

	// Clock
	always #2 clk = ~clk;

	// Hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [23:0] x, input logic [23:0] y);
		num_checks++;
		if (y !== x)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, x, y);
		end
	endtask

	// One transfer; b selects bit access, r a read, p the pin path
	task automatic op(input logic b, input logic r, input logic p, input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		#1;
		{addr, wdat, rdp, baddr, bwd} = {ad, d, p, ad, d[0]};
		{wr, rd, bwr, brd} = {~b & ~r, ~b & r, b & ~r, b & r};
		@(posedge clk);
		#1;
		{wr, rd, bwr, brd} = 4'h0;
		g = rdat;
		if (r)
			chk("rvalid", 24'h00_0001, {23'h00_0000, rvld});
		else if (b & (ad[7:3] inside {5'h10, 5'h12, 5'h14}))
			mdl[{ad[7:3], 3'h0}][ad[2:0]] = d[0];
		else if (~b & mdl.exists(ad))
			mdl[ad] = (ad == 8'hB4) ? d & 8'h37 : d;
	endtask

	function automatic logic [23:0] lat();
		return {8'(mdl[8'hA0]), 8'(mdl[8'h90]), 8'(mdl[8'h80])};
	endfunction

	function automatic logic [23:0] eoe();
		return ~(alt_en & alt_out | ~alt_en & lat());
	endfunction

	task automatic rd_all();
		for (int j = 0; j < 8; j++)
		begin
			op(1'b0, 1'b1, 1'b0, ADR[j], 8'h00);
			chk("reg", 24'(mdl.exists(ADR[j]) ? mdl[ADR[j]] : 0), {16'h0000, g});
		end
	endtask

	// Pin drive and pull-up outputs against the model
	task automatic pins_ok();
		chk("oe", eoe(), oe);
		chk("out", 24'h00_0000, pout & oe);
		chk("level", ~eoe(), pout);
		chk("pu", ~{5'h00, 3'(mdl[8'hB4]), 8'(mdl[8'hB3]), 8'(mdl[8'hB2])}, pu);
		chk("ea rst pu", {22'h00_0000, ~mdl[8'hB4][4], ~mdl[8'hB4][5]}, {22'h00_0000, ea_pu, rs_pu});
	endtask

	// Which pins toggle over 20 cycles, and the last toggle spacing
	task automatic watch();
		logic [23:0] p;
		int          last;
		repeat (3) @(posedge clk);
		#1;
		p = oe;
		last = -1;
		ch = 24'h00_0000;
		iv = -1;
		for (int i = 0; i < 20; i++)
		begin
			@(posedge clk);
			#1;
			if (oe !== p)
			begin
				ch = ch | (oe ^ p);
				iv = (last < 0) ? -1 : i - last;
				last = i;
			end
			p = oe;
		end
	endtask

	// Main sequence
	initial
	begin
		a = $urandom(29143);
		for (int j = 0; j < 7; j++)
			mdl[ADR[j]] = (j < 3) ? 8'hFF : 8'h00;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		rd_all();
		pins_ok();
		$display("reset test done");
		repeat (3)
		begin
			for (int j = 0; j < 8; j++)
				op(1'b0, 1'b0, 1'b0, ADR[j], 8'($urandom));
			rd_all();
			pins_ok();
		end
		$display("register test done");
		repeat (24)
		begin
			a = int'(ADR[$urandom_range(0, 3)] | 8'($urandom_range(0, 7)));
			op(1'b1, 1'b0, 1'b0, 8'(a), 8'($urandom));
			op(1'b1, 1'b1, 1'b0, 8'(a), 8'h00);
			chk("bit", 24'((a[7:3] inside {5'h10, 5'h12, 5'h14}) ? mdl[a & 8'hF8][a[2:0]] : 0), {16'h0000, g});
		end
		rd_all();
		$display("bit test done");
		repeat (4)
		begin
			for (int j = 0; j < 3; j++)
				op(1'b0, 1'b0, 1'b0, ADR[j], 8'($urandom));
			alt_en = 24'($urandom) & lat();
			alt_out = 24'($urandom);
			xen = 24'($urandom) & lat();
			xval = 24'($urandom);
			repeat (8) @(posedge clk);
			#1;
			pins_ok();
			e = ~eoe() & (xen & xval | ~xen);
			for (int j = 0; j < 3; j++)
			begin
				op(1'b0, 1'b1, 1'b1, ADR[j], 8'h00);
				chk("pin", 24'(e[8*j +: 8]), {16'h0000, g});
			end
			rd_all();
		end
		$display("pin test done");
		alt_en = 24'h00_0000;
		xen = 24'h00_0000;
		for (int j = 0; j < 3; j++)
			op(1'b0, 1'b0, 1'b0, ADR[j], 8'hFF);
		gen = 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			op(1'b0, 1'b0, 1'b0, 8'h9F, 8'h01 << k);
			watch();
			chk("mod pins", 24'h00_0001 << piom_pkg::MOD_PIN[k], ch);
			chk("half period", 24'(HALF), 24'(iv));
		end
		op(1'b0, 1'b0, 1'b0, 8'h9F, 8'hFF);
		gen = 1'b0;
		watch();
		chk("mod off", 24'h00_0000, ch);
		$display("modulation test done");
		// Reset again in mid-run: everything must fall back to its reset state
		@(posedge clk);
		#1;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int j = 0; j < 7; j++)
			mdl[ADR[j]] = (j < 3) ? 8'hFF : 8'h00;
		rd_all();
		pins_ok();
		$display("second reset test done");
		test_done();
	end
endmodule
